// ---- src/pta_phy_test_mgmt.sv ----
// Contract
// - test packet: 54-bit dummy header, 240-bit text repeated to 256 bytes, last 8 bits zero
// - test entry waits until pending transmissions have drained
// - enable bit: 0 leaves test mode, 1 enters test mode
// - pattern mode 0 sends continuously, 1 sends half the time
// - modulation codes 0-2 uncoded, 4-6 coded, 3 and 7 unused
// - power code steps transmit level down 3 dB each, 21 dB at 7
// - every test-mode request gets a confirm, except one refused with SLVERR while another is open
// - test confirm: 0 success, 1 internal failure, 2 already in test mode
// - attribute reply status: 0 ok, 1 failed, 2 unsupported identifier
// - attribute reply returns identifier and its current value
`include "pta_consts.svh"
`default_nettype none
module pta_phy_test_mgmt #(
  parameter logic [53:0] DUMMY_HDR = 54'h0,
  parameter logic [239:0] REF_TEXT = "PHY TEST REFERENCE MESSAGE 01 "
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transmit path
  input wire logic txBusy,
  output logic txOn,
  output logic txBit,
  output logic [1:0] txScheme,
  output logic txCoded,
  output logic [4:0] txAttenDb,
  output logic testMode,
  output logic replyStrobe
);
  pta_pkg::pta_state_e state;
  logic reqEnable, reqMode, reqIsTest;
  logic [2:0] reqMod, reqPwr;
  logic cfgMode;
  logic [2:0] cfgMod, cfgPwr;
  logic [1:0] testResult, attrStatus;
  logic [15:0] queryId, attrId, pktCount;
  logic [31:0] attrValue;
  logic [7:0] replySeq;
  logic [10:0] bitIdx;
  logic [7:0] txtIdx;
  logic gapPhase;

  // request decode; a request arriving while one is open is refused
  wire wrFire = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
  wire rdFire = s_axi_arready & s_axi_arvalid;
  wire idle = (state == pta_pkg::ST_IDLE);
  wire hitCtrl = (s_axi_awaddr == `PTA_OFS_TEST_CTRL);
  wire hitQuery = (s_axi_awaddr == `PTA_OFS_ATTR_QUERY);
  wire testReq = wrFire & hitCtrl & s_axi_wstrb[0] & idle;
  wire queryReq = wrFire & hitQuery & s_axi_wstrb[0] & idle;
  wire wrBad = wrFire & ~((hitCtrl | hitQuery) & idle);
  wire [15:0] newId = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : queryId[15:8], s_axi_wdata[7:0]};
  wire newEnable = s_axi_wdata[`PTA_BIT_ENABLE];
  wire [2:0] newMod = s_axi_wdata[`PTA_POS_MOD +: 3];

  // attribute lookup for the identifier just written
  wire idState = (newId == `PTA_ATTR_TEST_STATE);
  wire idCount = (newId == `PTA_ATTR_PKT_COUNT);
  wire idCfg = (newId == `PTA_ATTR_TEST_CFG);
  wire [31:0] lookValue = idState ? {31'h0, testMode} :
                          idCount ? {16'h0, pktCount} :
                          (idCfg & testMode) ? {25'h0, cfgPwr, cfgMod, cfgMode} : 32'h0;
  // config has no meaning outside test mode, so that read reports failure
  wire [1:0] lookStatus = (idState | idCount) ? `PTA_RES_OK :
                          idCfg ? (testMode ? `PTA_RES_OK : `PTA_RES_FAIL) : `PTA_RES_UNSUP;

  // command sequencer: one open request at a time, confirm in DONE
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= pta_pkg::ST_IDLE;
      reqEnable <= 1'b0;
      reqMode <= 1'b0;
      reqMod <= 3'h0;
      reqPwr <= 3'h0;
      reqIsTest <= 1'b0;
      queryId <= 16'h0;
      testMode <= 1'b0;
      cfgMode <= 1'b0;
      cfgMod <= 3'h0;
      cfgPwr <= 3'h0;
      testResult <= `PTA_RES_OK;
      attrId <= 16'h0;
      attrStatus <= `PTA_RES_OK;
      attrValue <= 32'h0;
      replySeq <= 8'h0;
      replyStrobe <= 1'b0;
    end else begin
      replyStrobe <= 1'b0;
      case (state)
        pta_pkg::ST_IDLE: begin
          if (testReq) begin
            reqEnable <= newEnable;
            reqMode <= s_axi_wdata[`PTA_BIT_MODE];
            reqMod <= newMod;
            reqPwr <= s_axi_wdata[`PTA_POS_PWR +: 3];
            reqIsTest <= 1'b1;
            if (newEnable && testMode) begin
              testResult <= `PTA_RES_ALREADY;
              state <= pta_pkg::ST_DONE;
            end else if (newEnable) begin
              state <= pta_pkg::ST_DRAIN;
            end else begin
              testMode <= 1'b0;
              testResult <= `PTA_RES_OK;
              state <= pta_pkg::ST_DONE;
            end
          end else if (queryReq) begin
            queryId <= newId;
            reqIsTest <= 1'b0;
            attrId <= newId;
            attrValue <= lookValue;
            attrStatus <= lookStatus;
            state <= pta_pkg::ST_DONE;
          end
        end
        pta_pkg::ST_DRAIN: begin
          // hold the switch until the transmit buffer has emptied
          if (!txBusy) begin
            if (reqMod[1:0] == 2'b11) begin
              testResult <= `PTA_RES_FAIL;
            end else begin
              testMode <= 1'b1;
              cfgMode <= reqMode;
              cfgMod <= reqMod;
              cfgPwr <= reqPwr;
              testResult <= `PTA_RES_OK;
            end
            state <= pta_pkg::ST_DONE;
          end
        end
        pta_pkg::ST_DONE: begin
          replyStrobe <= 1'b1;
          replySeq <= replySeq + 8'h01;
          state <= pta_pkg::ST_IDLE;
        end
        default: state <= pta_pkg::ST_IDLE;
      endcase
    end
  end

  // reference packet bit selection, msb first within each character
  wire active = testMode & ~gapPhase;
  wire [7:0] txtPos = `PTA_TXT_LAST - txtIdx;
  wire [5:0] hdrPos = 6'h35 - bitIdx[5:0];
  wire inHdr = (bitIdx < `PTA_HDR_BITS);
  wire inFlush = (bitIdx >= `PTA_FLUSH_START);
  wire pktEnd = (bitIdx == `PTA_PKT_LAST);
  wire sendBit = inHdr ? DUMMY_HDR[hdrPos] : (inFlush ? 1'b0 : REF_TEXT[txtPos]);

  // packet generator; in half-duty mode an idle slot of one packet length follows
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bitIdx <= 11'h0;
      txtIdx <= 8'h0;
      gapPhase <= 1'b0;
      pktCount <= 16'h0;
    end else if (!testMode) begin
      bitIdx <= 11'h0;
      txtIdx <= 8'h0;
      gapPhase <= 1'b0;
    end else begin
      bitIdx <= bitIdx + 11'h001; // wraps after 2048 bits = 256 bytes
      if (active && !inHdr) begin
        txtIdx <= (txtIdx == `PTA_TXT_LAST) ? 8'h0 : txtIdx + 8'h01;
      end
      if (pktEnd) begin
        txtIdx <= 8'h0;
        gapPhase <= cfgMode & ~gapPhase;
        if (active) begin
          pktCount <= pktCount + 16'h0001;
        end
      end
    end
  end

  // transmit outputs registered for clean timing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txOn <= 1'b0;
      txBit <= 1'b0;
      txScheme <= 2'h0;
      txCoded <= 1'b0;
      txAttenDb <= 5'h0;
    end else begin
      txOn <= active;
      txBit <= active & sendBit;
      txScheme <= cfgMod[1:0];
      txCoded <= cfgMod[2];
      txAttenDb <= 5'(cfgPwr) * `PTA_DB_STEP;
    end
  end

  // read data mux
  wire [31:0] rdMux =
    (s_axi_araddr == `PTA_OFS_TEST_CTRL) ? {24'h0, reqPwr, reqMod, reqMode, reqEnable} :
    (s_axi_araddr == `PTA_OFS_ATTR_QUERY) ? {16'h0, queryId} :
    (s_axi_araddr == `PTA_OFS_TEST_REPLY) ?
      {~idle, 15'h0, replySeq, 3'h0, reqIsTest, 2'h0, testResult} :
    (s_axi_araddr == `PTA_OFS_ATTR_STATUS) ? {attrId, 14'h0, attrStatus} :
    (s_axi_araddr == `PTA_OFS_ATTR_VALUE) ? attrValue :
    (s_axi_araddr == `PTA_OFS_STATUS) ? {pktCount, 13'h0, gapPhase, txOn, testMode} : 32'h0;
  wire rdMapped = (s_axi_araddr <= `PTA_OFS_STATUS) & (s_axi_araddr[1:0] == 2'b00);

  // axi slave: address and data taken together, one beat open per direction
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PTA_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PTA_RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrBad ? `PTA_RESP_SLVERR : `PTA_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdMapped ? `PTA_RESP_OKAY : `PTA_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  property p_reply_done;
    @(posedge sys_clk) disable iff (!resetn)
      state == pta_pkg::ST_DONE |=> replyStrobe ##1 !replyStrobe;
  endproperty
  a_reply_done: assert property (p_reply_done) else $error("confirm not single pulse");

  property p_test_confirm;
    @(posedge sys_clk) disable iff (!resetn)
      testReq && (newEnable == 1'b0 || testMode) |=> ##1 replyStrobe;
  endproperty
  a_test_confirm: assert property (p_test_confirm) else $error("test confirm late");

  property p_drain;
    @(posedge sys_clk) disable iff (!resetn)
      state == pta_pkg::ST_DRAIN && txBusy |=> state == pta_pkg::ST_DRAIN && !testMode;
  endproperty
  a_drain: assert property (p_drain) else $error("entered test mode while busy");

  property p_already;
    @(posedge sys_clk) disable iff (!resetn)
      testReq && newEnable && testMode |=> testResult == `PTA_RES_ALREADY ##1 replyStrobe;
  endproperty
  a_already: assert property (p_already) else $error("already code missing");

  property p_exit;
    @(posedge sys_clk) disable iff (!resetn)
      testReq && !newEnable |=> !testMode ##1 !txOn;
  endproperty
  a_exit: assert property (p_exit) else $error("test mode not left");

  property p_unused_mod;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(testMode) |-> cfgMod[1:0] != 2'b11;
  endproperty
  a_unused_mod: assert property (p_unused_mod) else $error("unused modulation accepted");

  property p_flush;
    @(posedge sys_clk) disable iff (!resetn)
      active && inFlush |=> txOn && !txBit;
  endproperty
  a_flush: assert property (p_flush) else $error("flush bit not zero");

  property p_duty;
    @(posedge sys_clk) disable iff (!resetn)
      active && pktEnd && cfgMode && $stable(testMode) |=> ##1 !txOn [*8];
  endproperty
  a_duty: assert property (p_duty) else $error("no idle slot in half duty");

  property p_atten;
    @(posedge sys_clk) disable iff (!resetn)
      testMode && cfgPwr == 3'h7 && $stable(cfgPwr) |=> txAttenDb == 5'h15;
  endproperty
  a_atten: assert property (p_atten) else $error("attenuation wrong");

  property p_unsup;
    @(posedge sys_clk) disable iff (!resetn)
      queryReq && !(idState | idCount | idCfg) |=>
        attrStatus == `PTA_RES_UNSUP && attrId == $past(newId);
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported id not flagged");

  c_enter: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(testMode));
  c_query: cover property (@(posedge sys_clk) disable iff (!resetn) queryReq ##2 replyStrobe);
  c_gap: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(gapPhase));
endmodule
`default_nettype wire

// ---- shared/pta_consts.svh ----
`ifndef PTA_CONSTS_SVH
`define PTA_CONSTS_SVH
// register byte offsets
`define PTA_OFS_TEST_CTRL 8'h00
`define PTA_OFS_ATTR_QUERY 8'h04
`define PTA_OFS_TEST_REPLY 8'h08
`define PTA_OFS_ATTR_STATUS 8'h0C
`define PTA_OFS_ATTR_VALUE 8'h10
`define PTA_OFS_STATUS 8'h14
// test control field positions
`define PTA_BIT_ENABLE 0
`define PTA_BIT_MODE 1
`define PTA_POS_MOD 2
`define PTA_POS_PWR 5
// result codes
`define PTA_RES_OK 2'h0
`define PTA_RES_FAIL 2'h1
`define PTA_RES_ALREADY 2'h2
`define PTA_RES_UNSUP 2'h2
// attribute identifiers
`define PTA_ATTR_TEST_STATE 16'h0010
`define PTA_ATTR_PKT_COUNT 16'h0011
`define PTA_ATTR_TEST_CFG 16'h0012
// reference packet layout, in bits
`define PTA_HDR_BITS 11'h036
`define PTA_TXT_LAST 8'hEF
`define PTA_FLUSH_START 11'h7F8
`define PTA_PKT_LAST 11'h7FF
// attenuation per power step, dB
`define PTA_DB_STEP 5'h03
// axi responses
`define PTA_RESP_OKAY 2'h0
`define PTA_RESP_SLVERR 2'h2
`endif

// ---- shared/pta_pkg.sv ----
package pta_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DRAIN = 3'b010,
    ST_DONE = 3'b100
  } pta_state_e;
endpackage

// ---- bench/pta_tx_buffer_model.sv ----
`default_nettype none
// transmit queue beside the block: busy while queued words remain
module pta_tx_buffer_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // queue loading from the bench
  input wire logic load,
  input wire logic [7:0] loadCount,
  // towards the block
  output logic txBusy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pending;
  // one word leaves per cycle, so the drain time is exactly the loaded count
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) pending <= 8'h00;
    else if (load) pending <= loadCount;
    else if (pending != 8'h00) pending <= pending - 8'h01;
  end
  assign txBusy = (pending != 8'h00);
endmodule
`default_nettype wire

// ---- bench/pta_phy_test_mgmt_tb.sv ----
`include "pta_consts.svh"
`default_nettype none
module pta_phy_test_mgmt_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [53:0] HDR = 54'h2A5A5C3C30F0F1;
  localparam logic [239:0] TXT = "LINE TEST PAYLOAD TEXT 0123456";
  logic sys_clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, txBusy, txOn, txBit, txCoded, testMode;
  logic replyStrobe, load, cap;
  logic [7:0] awaddr, araddr, loadCount;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, txScheme, r;
  logic [4:0] txAttenDb;
  logic capBits [2048];
  int failures = 0;
  int checked = 0;
  int strobes = 0;
  int capIdx = 0;

  pta_phy_test_mgmt #(.DUMMY_HDR(HDR), .REF_TEXT(TXT)) u_dut (
    .sys_clk(sys_clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .txBusy(txBusy), .txOn(txOn), .txBit(txBit), .txScheme(txScheme), .txCoded(txCoded),
    .txAttenDb(txAttenDb), .testMode(testMode), .replyStrobe(replyStrobe));
  pta_tx_buffer_model u_buf (.sys_clk(sys_clk), .resetn(resetn), .load(load),
    .loadCount(loadCount), .txBusy(txBusy));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // confirm counter and packet capture, sampled mid-cycle where outputs are settled
  always @(negedge sys_clk) begin
    if (replyStrobe === 1'b1) strobes++;
    if (cap && txOn === 1'b1 && capIdx < 2048) begin
      capBits[capIdx] = txBit;
      capIdx++;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // waits are open ended, the watchdog ends a hang; the last edge keeps
  // a following call from driving the ready line twice in one step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge sys_clk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // waits for confirm number target, then makes sure no extra one follows
  task automatic wait_reply(input int target);
    for (int n = 0; n < 100 && strobes < target; n++) @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
    chk("confirm count", target, strobes);
    @(posedge sys_clk);
  endtask

  task automatic query(input logic [15:0] id, input int target, input logic [1:0] st);
    axi_wr(`PTA_OFS_ATTR_QUERY, {16'h0000, id});
    wait_reply(target);
    axi_rd(`PTA_OFS_ATTR_STATUS);
    chk("attr id", {id, 16'h0000}, d & 32'hFFFF0000);
    chk("attr status", st, d & 32'h3);
    axi_rd(`PTA_OFS_ATTR_VALUE);
  endtask

  task automatic t_drain_entry();
    cap = 1'b1;
    load <= 1'b1;
    loadCount <= 8'h28;
    @(posedge sys_clk);
    load <= 1'b0;
    axi_wr(`PTA_OFS_TEST_CTRL, 32'h000000F5);
    chk("entry resp", `PTA_RESP_OKAY, r);
    axi_wr(`PTA_OFS_ATTR_QUERY, 32'h00000010);
    chk("open resp", `PTA_RESP_SLVERR, r);
    chk("mode while busy", 32'h2, {30'h0, txBusy, testMode});
    wait_reply(1);
    axi_rd(`PTA_OFS_TEST_REPLY);
    chk("entry result", 32'h10, d & 32'h13);
    chk("outputs", 32'h3B5, {txOn, testMode, txCoded, txScheme, txAttenDb});
    $display("test drain_entry done");
  endtask

  task automatic t_stream();
    logic e;
    for (int n = 0; n < 2200 && capIdx < 2048; n++) @(negedge sys_clk);
    for (int i = 0; i < 2048; i++) begin
      e = (i < 54) ? HDR[53 - i] : (i >= 2040) ? 1'b0 : TXT[239 - ((i - 54) % 240)];
      chk("packet bit", {31'h0, e}, {31'h0, capBits[i]});
    end
    @(posedge sys_clk);
    $display("test stream done");
  endtask

  task automatic t_dup_attr();
    axi_wr(`PTA_OFS_TEST_CTRL, 32'h00000001);
    wait_reply(2);
    axi_rd(`PTA_OFS_TEST_REPLY);
    chk("dup result", `PTA_RES_ALREADY, d & 32'h3);
    chk("dup keeps power", 32'h15, txAttenDb);
    query(`PTA_ATTR_TEST_STATE, 3, `PTA_RES_OK);
    chk("attr value", 32'h1, d);
    query(16'h0077, 4, `PTA_RES_UNSUP);
    chk("unsup value", 32'h0, d);
    $display("test dup_attr done");
  endtask

  task automatic t_leave_fail();
    axi_wr(`PTA_OFS_TEST_CTRL, 32'h00000000);
    wait_reply(5);
    chk("left", 32'h0, {txOn, testMode});
    // a write without the low byte lane is acknowledged but starts no request
    wstrb <= 4'h0;
    axi_wr(`PTA_OFS_TEST_CTRL, 32'h00000001);
    chk("no lane resp", `PTA_RESP_OKAY, r);
    wait_reply(5);
    chk("no lane mode", 32'h0, testMode);
    wstrb <= 4'hF;
    axi_wr(`PTA_OFS_TEST_CTRL, 32'h0000000D);
    wait_reply(6);
    axi_rd(`PTA_OFS_TEST_REPLY);
    chk("bad mod result", `PTA_RES_FAIL, d & 32'h3);
    chk("bad mod stays out", 32'h0, testMode);
    query(`PTA_ATTR_TEST_CFG, 7, `PTA_RES_FAIL);
    chk("cfg value", 32'h0, d);
    // the first session lasted one full packet and less than two
    query(`PTA_ATTR_PKT_COUNT, 8, `PTA_RES_OK);
    chk("packet count", 32'h1, d);
    axi_rd(`PTA_OFS_STATUS);
    chk("status reg", 32'h00010000, d);
    axi_rd(8'h40);
    chk("unmapped resp", `PTA_RESP_SLVERR, r);
    chk("unmapped data", 32'h0, d);
    $display("test leave_fail done");
  endtask

  task automatic t_half_duty();
    int on;
    on = 0;
    axi_wr(`PTA_OFS_TEST_CTRL, 32'h00000003);
    wait_reply(9);
    chk("plain outputs", 32'h100, {testMode, txCoded, txScheme, txAttenDb});
    axi_rd(`PTA_OFS_TEST_CTRL);
    chk("ctrl readback", 32'h3, d);
    repeat (4096) begin
      @(negedge sys_clk);
      if (txOn === 1'b1) on++;
    end
    chk("on cycles", 32'h800, on);
    @(posedge sys_clk);
    axi_wr(`PTA_OFS_TEST_CTRL, 32'h00000000);
    wait_reply(10);
    $display("test half_duty done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog: the sequence needs about 6300 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    report_and_stop();
  end

  // reset, then the scenarios in order
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, load, cap} = 8'h00;
    {awaddr, araddr, loadCount, wdata} = 56'h0;
    wstrb = 4'hF;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_drain_entry();
    t_stream();
    t_dup_attr();
    t_leave_fail();
    t_half_duty();
    report_and_stop();
  end
endmodule
`default_nettype wire
